// >>> hdl/gdfs_pkg.sv
// Behaviour
// - Held-low status line gives external fault, delayed off
// - Command edges in normal run, and the re-arm edge, answered by short low pulse
// - Faults: desaturation, secondary undervoltage, external input
// - Status line high idle, low while pulsing
// - Short circuit reported after detection response time
// - Short-circuit pulse lasts 8 us plus delay
// - Gate off after response time plus delay
// - Re-arm needs fault end then falling edge
// - Undervoltage fault shown while undervoltage lasts
// - Power-up shows fault until undervoltage releases
// - Primary undervoltage flagged, gate not switched off
// - Host blocks command on primary undervoltage
// - Secondary undervoltage: delayed gate off, block channel
// - Boost logic derives delay and 1-5 us pulse; here BOOST_CYC is only range-checked and added to the host turn-on spacing
// - Host spaces turn-on commands by minimum interval
// - Falling command edge on, rising edge off
// - Fault delay 0.2 us open, else pF/50 us
// - Command turn-off honoured during fault delay
// - Boost timing signal mirrors gate turn-on
package gdfs_pkg;
  // Clock period in picoseconds
  localparam int unsigned CLK_PS = 4000;
  // Fault delay with delay pin left open, in ns
  localparam int unsigned DLY_OPEN_NS = 200;
  // Delay per capacitance: pF divided by this gives us
  localparam int unsigned DLY_PF_PER_US = 50;
  // Cycles of the open-pin delay, rounded down (shorter time)
  localparam int unsigned DLY_OPEN_CYC = (DLY_OPEN_NS * 1000) / CLK_PS;
  // Fixed part of the short-circuit clear interval, in ns
  localparam int unsigned SC_CLR_NS = 8000;
  localparam int unsigned SC_CLR_CYC = (SC_CLR_NS * 1000) / CLK_PS;
  // Picoseconds per pF of delay capacitance: 1000 ns / 50 pF = 20 ns per pF
  localparam int unsigned DLY_PS_PER_PF = 1000000 / DLY_PF_PER_US;
  // Boost pulse window (far side), in ns
  localparam int unsigned BOOST_MIN_NS = 1000;
  localparam int unsigned BOOST_MAX_NS = 5000;
  localparam int unsigned BOOST_MIN_CYC = (BOOST_MIN_NS * 1000 + CLK_PS - 1) / CLK_PS;
  localparam int unsigned BOOST_MAX_CYC = (BOOST_MAX_NS * 1000) / CLK_PS;
  // Turn-on spacing base figures, in us and nF
  localparam int unsigned TMIN_BASE_US = 11;
  localparam int unsigned TMIN_CAP_NF = 22;
  // Counter width shared by both ends
  localparam int unsigned CNT_W = 20;
  // Fault causes as reported by the device
  typedef enum logic [3:0] {
    GDFS_F_NONE = 4'h1,
    GDFS_F_DESAT = 4'h2,
    GDFS_F_UV = 4'h4,
    GDFS_F_EXT = 4'h8
  } gdfs_fault_t;
endpackage

// >>> hdl/gdfs_if.sv
`timescale 1ns/1ps
// Isolated command and status lines between host and driver
interface gdfs_if;
  logic cmd_n; // Gate command, low means on
  logic stat_drv_o; // Device pulls status line (0 = pulling low)
  logic stat_oe_n_dev; // Device output enable, low = driving
  logic stat_oe_n_host; // Host output enable, low = driving (pulls low)
  logic stat_lvl; // Resolved status line level
  logic prim_uv; // Primary under-voltage status
  // Open drain with pull-up: low when any side drives low
  assign stat_lvl = !((!stat_oe_n_dev && !stat_drv_o) || !stat_oe_n_host);
  modport dev (input cmd_n, input stat_lvl, output stat_drv_o, output stat_oe_n_dev,
    output prim_uv);
  modport host (output cmd_n, input stat_lvl, output stat_oe_n_host, input prim_uv);
endinterface

// >>> hdl/gdfs_dev.sv
`timescale 1ns/1ps
// Driver secondary side: edge acknowledge, fault detect, gate control
module gdfs_dev
  import gdfs_pkg::*;
#(
  parameter int unsigned ACK_CYC = 100, // Acknowledge pulse length
  parameter int unsigned EXT_CYC = 500, // External fault pulse length
  parameter int unsigned RESP_CYC = 250, // Desaturation response time
  parameter int unsigned EXTHOLD_CYC = 50, // Minimum external hold
  parameter int unsigned CAP_PF = 0 // Delay capacitor, 0 = pin open
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Link to host
  gdfs_if.dev lnk,
  // Analog monitor inputs
  input wire logic desat_i,
  input wire logic sec_uv_i,
  input wire logic prim_uv_i,
  // Gate outputs
  output logic gate_turnon_pin_o,
  output logic boost_timing_signal_o,
  output gdfs_fault_t fault_o
);
  // Fault delay: open pin or capacitance based
  localparam int unsigned DLY_CYC = (CAP_PF == 0) ? DLY_OPEN_CYC :
    (CAP_PF * DLY_PS_PER_PF) / CLK_PS;
  localparam int unsigned SC_CYC = SC_CLR_CYC + DLY_CYC;
  // Pulse lengths must differ, or the host cannot tell them apart
  if (ACK_CYC == 0 || ACK_CYC == EXT_CYC || ACK_CYC == SC_CYC ||
      EXT_CYC == SC_CYC) begin : g_chk
    $error("gdfs_dev: pulse lengths must be distinct");
  end
  // A zero filter or hold length would raise a fault on every cycle
  if (RESP_CYC == 0 || EXTHOLD_CYC == 0 || EXT_CYC == 0) begin : g_chk_zero
    $error("gdfs_dev: filter and pulse lengths must be nonzero");
  end
  // Every count except EXT_CYC is checked against the shared counter width
  if (SC_CYC >= (1 << CNT_W) || RESP_CYC >= (1 << CNT_W) ||
      EXTHOLD_CYC >= (1 << CNT_W) || ACK_CYC >= (1 << CNT_W)) begin : g_chk_cnt
    $error("gdfs_dev: count too wide for the counters");
  end
  // Delay capacitor above its range, or a delay shorter than one cycle
  if (CAP_PF > 10000 || DLY_CYC == 0) begin : g_chk_dly
    $error("gdfs_dev: bad delay capacitor");
  end

  typedef enum logic [3:0] {
    GDFS_S_RUN = 4'h1, // Normal, acknowledge edges
    GDFS_S_DLY = 4'h2, // Fault turn-off delay running
    GDFS_S_IND = 4'h4, // Fault pulse on status line
    GDFS_S_BLK = 4'h8 // Indication over, waiting for re-arm edge
  } gdfs_st_t;

  typedef struct packed {
    gdfs_st_t st;
    gdfs_fault_t cause;
    logic cmd_q; // Previous command level
    logic gate; // Gate on
    logic [CNT_W-1:0] ack_cnt; // Acknowledge pulse left
    logic [CNT_W-1:0] cnt; // Fault turn-off delay counter
    logic [CNT_W-1:0] ind_cnt; // Fault pulse left
    logic [CNT_W-1:0] resp_cnt; // Desaturation filter
    logic [CNT_W-1:0] ext_cnt; // External low hold counter
    logic low; // Status line pulled low
  } gdfs_dev_t;

  gdfs_dev_t s_q, s_d;

  // Next-state logic: one copy of the state, edited then registered
  always_comb begin
    logic fall; // Command fell since last edge
    logic rise; // Command rose since last edge
    logic ext_hit; // External hold time reached
    logic desat_hit; // Desaturation outlasted the filter
    fall = 1'b0;
    rise = 1'b0;
    ext_hit = 1'b0;
    desat_hit = 1'b0;
    s_d = s_q;
    // Edge detect against the previous command sample
    fall = s_q.cmd_q && !lnk.cmd_n;
    rise = !s_q.cmd_q && lnk.cmd_n;
    s_d.cmd_q = lnk.cmd_n;
    // Desaturation must persist for the response time; a glitch restarts it
    if (desat_i && s_q.gate) begin
      // Saturate so a long short circuit does not wrap the filter
      if (s_q.resp_cnt != CNT_W'(RESP_CYC)) begin
        s_d.resp_cnt = s_q.resp_cnt + 1'b1;
      end
    end else begin
      // Gate off or collector healthy: filter starts over
      s_d.resp_cnt = '0;
    end
    desat_hit = (s_q.resp_cnt == CNT_W'(RESP_CYC));
    // External low seen only while we are not pulling ourselves
    if (!lnk.stat_lvl && !s_q.low) begin
      // Saturate at the hold time
      if (s_q.ext_cnt != CNT_W'(EXTHOLD_CYC)) begin
        s_d.ext_cnt = s_q.ext_cnt + 1'b1;
      end
    end else begin
      // Too short a pull is forgotten, the line needs a real hold
      s_d.ext_cnt = '0;
    end
    ext_hit = (s_q.ext_cnt == CNT_W'(EXTHOLD_CYC));
    // Acknowledge pulse runs down by itself
    if (s_q.ack_cnt != '0) begin
      s_d.ack_cnt = s_q.ack_cnt - 1'b1;
    end
    // Fault pulse runs down by itself, even through the delay
    if (s_q.ind_cnt != '0) begin
      s_d.ind_cnt = s_q.ind_cnt - 1'b1;
    end
    case (s_q.st)
      GDFS_S_RUN: begin
        // Command edges: falling on, rising off, each acknowledged
        if (fall) begin
          s_d.gate = 1'b1;
        end
        if (rise) begin
          s_d.gate = 1'b0;
        end
        // Ack restarts on every edge, even mid-pulse
        if (fall || rise) begin
          s_d.ack_cnt = CNT_W'(ACK_CYC);
        end
        // Any of the three fault sources starts the turn-off delay
        if (sec_uv_i || desat_hit || ext_hit) begin
          // Priority: under-voltage, desaturation, external
          if (sec_uv_i) begin
            s_d.cause = GDFS_F_UV;
          end else if (desat_hit) begin
            s_d.cause = GDFS_F_DESAT;
          end else begin
            s_d.cause = GDFS_F_EXT;
          end
          s_d.st = GDFS_S_DLY;
          s_d.cnt = CNT_W'(DLY_CYC);
          // A running acknowledge merges into the longer fault pulse
          s_d.ack_cnt = '0;
          // Fault pulse starts now, gate goes off after the delay
          if (desat_hit) begin
            s_d.ind_cnt = CNT_W'(SC_CYC);
          end else begin
            s_d.ind_cnt = CNT_W'(EXT_CYC);
          end
        end
      end
      GDFS_S_DLY: begin
        // A turn-off command may beat the delay
        if (rise) begin
          s_d.gate = 1'b0;
        end
        s_d.cnt = s_q.cnt - 1'b1;
        // Delay over: gate off whatever the command says
        if (s_q.cnt == CNT_W'(1)) begin
          s_d.gate = 1'b0;
          s_d.st = GDFS_S_IND;
        end
      end
      GDFS_S_IND: begin
        // Indication ends when pulse is done and no under-voltage remains
        if (s_q.ind_cnt == '0 && !sec_uv_i) begin
          s_d.st = GDFS_S_BLK;
        end
      end
      GDFS_S_BLK: begin
        // Channel blocked until a fresh turn-on edge
        if (sec_uv_i) begin
          s_d.st = GDFS_S_IND;
        end else if (fall) begin
          s_d.st = GDFS_S_RUN;
          s_d.cause = GDFS_F_NONE;
          s_d.gate = 1'b1;
          s_d.ack_cnt = CNT_W'(ACK_CYC);
        end
      end
      default: begin
        // Illegal code: park blocked with the gate off
        s_d.st = GDFS_S_BLK;
        s_d.gate = 1'b0;
      end
    endcase
    // Line low during ack, fault pulse, under-voltage or the turn-off delay
    // Taken from the next state so the pin moves with the state
    s_d.low = (s_d.ack_cnt != '0) || (s_d.ind_cnt != '0) || sec_uv_i ||
      (s_d.st == GDFS_S_DLY);
  end

  // State register; reset holds the line low as at power-up
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{st: GDFS_S_IND, cause: GDFS_F_UV, cmd_q: 1'b1, gate: 1'b0,
        ack_cnt: '0, cnt: '0, ind_cnt: '0, resp_cnt: '0, ext_cnt: '0,
        low: 1'b1};
    end else begin
      s_q <= s_d;
    end
  end

  // Open-drain status pin, enable low while pulling low
  assign lnk.stat_drv_o = 1'b0;
  assign lnk.stat_oe_n_dev = !s_q.low;
  // Primary under-voltage only reported, gate untouched
  assign lnk.prim_uv = prim_uv_i;
  // Gate and boost timing share one register so they never skew
  assign gate_turnon_pin_o = s_q.gate;
  assign boost_timing_signal_o = s_q.gate;
  // Cause stays until the channel re-arms
  assign fault_o = s_q.cause;
endmodule

// >>> hdl/gdfs_host.sv
`timescale 1ns/1ps
// Host controller end: command, pulse classification, external fault
module gdfs_host
  import gdfs_pkg::*;
#(
  parameter int unsigned ACK_MAX_CYC = 200, // Longer low pulses mean fault
  parameter int unsigned EXTHOLD_CYC = 50, // External fault hold time
  parameter int unsigned CGB_NF = 0, // Boost capacitance in nF
  parameter int unsigned BOOST_CYC = 500 // Boost pulse length
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // User side
  input wire logic gate_on_i,
  input wire logic ext_fault_i,
  output logic ack_o,
  output logic fault_o,
  output logic blocked_o,
  // Link to device
  gdfs_if.host lnk
);
  // Minimum turn-on spacing in cycles
  localparam int unsigned TMIN_CYC = (TMIN_BASE_US * 1000000 / CLK_PS) *
    (TMIN_CAP_NF + TMIN_CAP_NF + CGB_NF) / TMIN_CAP_NF + BOOST_CYC;
  if (BOOST_CYC < BOOST_MIN_CYC || BOOST_CYC > BOOST_MAX_CYC ||
      TMIN_CYC >= (1 << CNT_W) || ACK_MAX_CYC == 0) begin : g_chk
    $error("gdfs_host: bad parameters");
  end

  typedef struct packed {
    logic on; // Command state, 1 = gate on
    logic [CNT_W-1:0] gap; // Turn-on spacing counter
    logic [CNT_W-1:0] low_cnt; // Status low length
    logic [CNT_W-1:0] ext_cnt; // External pull left
    logic ack; // Ack pulse seen
    logic fault; // Fault pulse seen
    logic pulled; // Host pulling line
  } gdfs_host_t;

  gdfs_host_t s_q, s_d;

  // Next-state logic
  always_comb begin
    s_d = s_q;
    s_d.ack = 1'b0;
    s_d.fault = 1'b0;
    if (s_q.gap != '0) begin
      s_d.gap = s_q.gap - 1'b1;
    end
    // Primary under-voltage forces and keeps the command off
    if (lnk.prim_uv) begin
      s_d.on = 1'b0;
    end else if (gate_on_i && !s_q.on && s_q.gap == '0) begin
      s_d.on = 1'b1;
      s_d.gap = CNT_W'(TMIN_CYC);
    end else if (!gate_on_i) begin
      s_d.on = 1'b0;
    end
    // Classify low pulses by length, ignoring our own pull
    if (!lnk.stat_lvl && !s_q.pulled) begin
      s_d.low_cnt = (s_q.low_cnt == '1) ? s_q.low_cnt : s_q.low_cnt + 1'b1;
    end else begin
      s_d.low_cnt = '0;
      if (s_q.low_cnt != '0) begin
        s_d.ack = (s_q.low_cnt <= CNT_W'(ACK_MAX_CYC));
      end
    end
    s_d.fault = (s_d.low_cnt > CNT_W'(ACK_MAX_CYC));
    // External fault: hold line low for the hold time
    if (ext_fault_i && s_q.ext_cnt == '0) begin
      s_d.ext_cnt = CNT_W'(EXTHOLD_CYC + 1);
    end else if (s_q.ext_cnt != '0) begin
      s_d.ext_cnt = s_q.ext_cnt - 1'b1;
    end
    s_d.pulled = (s_d.ext_cnt != '0);
  end

  // State register
  always_ff @(posedge clk_i or posedge rst_i) begin
    if (rst_i) begin
      s_q <= '{on: 1'b0, gap: '0, low_cnt: '0, ext_cnt: '0, ack: 1'b0,
        fault: 1'b0, pulled: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Inverted command line: low means on
  assign lnk.cmd_n = !s_q.on;
  assign lnk.stat_oe_n_host = !s_q.pulled;
  assign ack_o = s_q.ack;
  assign fault_o = s_q.fault;
  assign blocked_o = lnk.prim_uv;
endmodule

// >>> sim/gdfs_sva.sv
`timescale 1ns/1ps
// Watches one host-device pair across the link
module gdfs_sva (
  // Clock and reset
  input logic clk_i,
  input logic rst_i,
  // Link signals
  input logic cmd_n,
  input logic stat_oe_n_dev,
  input logic stat_lvl,
  input logic prim_uv,
  // Device pins
  input logic desat_i,
  input logic sec_uv_i,
  input logic gate_turnon_pin_o,
  input logic boost_timing_signal_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // Acknowledge: low for the bench's four-cycle setting, then released
  sequence ack_pulse;
    !stat_oe_n_dev [*4] ##1 stat_oe_n_dev;
  endsequence
  // Turn-on edge reaching an idle, healthy device
  sequence on_edge;
    $fell(cmd_n) && stat_lvl && !sec_uv_i && !desat_i && !prim_uv;
  endsequence
  on_ack_a: assert property (on_edge |=> gate_turnon_pin_o ##0 ack_pulse)
    else $error("turn-on edge not acknowledged");
  off_edge_a: assert property ($rose(cmd_n) |=> !gate_turnon_pin_o)
    else $error("turn-off edge ignored");
  rise_cause_a: assert property ($rose(gate_turnon_pin_o) |->
    !$past(cmd_n) && $past(cmd_n, 2))
    else $error("gate rose without a falling command");
  // One cycle of slack for the monitor register
  uv_hold_a: assert property (sec_uv_i ##1 sec_uv_i |-> !stat_oe_n_dev)
    else $error("status released during under-voltage");
  desat_resp_a: assert property ((gate_turnon_pin_o && desat_i) [*4]
    |-> ##[0:2] !stat_oe_n_dev)
    else $error("desaturation not reported");
  desat_dly_a: assert property ($fell(stat_oe_n_dev) && desat_i && gate_turnon_pin_o
    |-> ##[48:52] $fell(gate_turnon_pin_o))
    else $error("desaturation turn-off delay wrong");
  uv_dly_a: assert property ($rose(sec_uv_i) && gate_turnon_pin_o
    |-> ##[48:54] $fell(gate_turnon_pin_o))
    else $error("under-voltage turn-off delay wrong");
  prim_keep_a: assert property ($rose(prim_uv) && gate_turnon_pin_o |=> gate_turnon_pin_o)
    else $error("device cut gate on primary fault");
  host_block_a: assert property (prim_uv [*3] |-> cmd_n)
    else $error("host kept command on");
  boost_same_a: assert property (boost_timing_signal_o == gate_turnon_pin_o)
    else $error("boost timing differs from gate");
endmodule

// >>> sim/tb_top.sv
`timescale 1ns/1ps
module tb_top;
  import gdfs_pkg::*;
  // Bench-driven inputs, power-up starts under secondary UV
  logic clk_i = 0, rst_i = 1, gate_on_i = 0, ext_fault_i = 0;
  logic desat_i = 0, sec_uv_i = 1, prim_uv_i = 0;
  // Observed outputs
  logic gate, boost, ack, hfault, blocked;
  gdfs_fault_t cause;
  int n_fail = 0, n_checks = 0, acks = 0;
  gdfs_if gdfs_if_i ();
  // Short pulse settings keep the run brief; delay pin open
  gdfs_dev #(.ACK_CYC(4), .EXT_CYC(12), .RESP_CYC(3), .EXTHOLD_CYC(3)) gdfs_dev_i (
    .clk_i(clk_i), .rst_i(rst_i), .lnk(gdfs_if_i), .desat_i(desat_i), .sec_uv_i(sec_uv_i),
    .prim_uv_i(prim_uv_i), .gate_turnon_pin_o(gate), .boost_timing_signal_o(boost),
    .fault_o(cause));
  // Host holds external pull longer than device needs
  gdfs_host #(.ACK_MAX_CYC(8)) gdfs_host_i (.clk_i(clk_i), .rst_i(rst_i),
    .gate_on_i(gate_on_i), .ext_fault_i(ext_fault_i), .ack_o(ack), .fault_o(hfault),
    .blocked_o(blocked), .lnk(gdfs_if_i));
  gdfs_sva gdfs_sva_i (.clk_i(clk_i), .rst_i(rst_i), .cmd_n(gdfs_if_i.cmd_n),
    .stat_oe_n_dev(gdfs_if_i.stat_oe_n_dev), .stat_lvl(gdfs_if_i.stat_lvl),
    .prim_uv(gdfs_if_i.prim_uv), .desat_i(desat_i), .sec_uv_i(sec_uv_i),
    .gate_turnon_pin_o(gate), .boost_timing_signal_o(boost));
  // 250 MHz clock
  initial begin
    forever #2 clk_i = ~clk_i;
  end
  // Host acknowledge counter
  always @(posedge clk_i) begin
    if (ack === 1'b1) acks++;
  end
  task chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_checks++;
    if (s !== e) begin
      n_fail++;
      $display("BAD %s exp %0h seen %0h", nm, e, s);
    end
  endtask
  // Inputs always move 1 ns after the rising edge
  task step(input int k);
    repeat (k) @(posedge clk_i);
    #1;
  endtask
  // Bounded waits; host turn-on spacing can stall up to ~6000 cycles
  task wgate(input logic v, output int n);
    n = 0;
    while (gate !== v && n < 8000) begin
      step(1);
      n++;
    end
  endtask
  task wlvl(input logic v, output int n);
    n = 0;
    while (gdfs_if_i.stat_lvl !== v && n < 8000) begin
      step(1);
      n++;
    end
  endtask
  task tally_and_finish;
    $display("checks %0d fails %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Main sequence
  initial begin
    int n, m;
    step(16);
    rst_i = 0;
    step(20);
    chk("pwrup", gdfs_if_i.stat_lvl, 0);
    sec_uv_i = 0;
    wlvl(1, n);
    $display("test pwrup done");
    gate_on_i = 1;
    wgate(1, n);
    chk("on", gate, 1);
    chk("boost", boost, 1);
    // Let the turn-on acknowledge finish so the two pulses stay apart
    step(10);
    gate_on_i = 0;
    wgate(0, n);
    step(20);
    chk("acks", acks, 2);
    $display("test ack done");
    gate_on_i = 1;
    wgate(1, n);
    chk("gap", n > 2 * TMIN_BASE_US * 1000000 / CLK_PS - 100, 1);
    step(10);
    desat_i = 1;
    wlvl(0, n);
    chk("resp", n inside {[3:6]}, 1);
    wgate(0, m);
    chk("dly", m inside {[48:52]}, 1);
    chk("cause", cause, GDFS_F_DESAT);
    chk("hfault", hfault, 1);
    desat_i = 0;
    wlvl(1, n);
    chk("clr", (n + m) inside {[SC_CLR_CYC + 47:SC_CLR_CYC + 53]}, 1);
    step(20);
    chk("blocked", gate, 0);
    gate_on_i = 0;
    step(10);
    gate_on_i = 1;
    wgate(1, n);
    chk("rearm", gate, 1);
    $display("test desat done");
    step(10);
    ext_fault_i = 1;
    step(1);
    ext_fault_i = 0;
    wlvl(0, n);
    step(12);
    chk("ext", cause, GDFS_F_EXT);
    chk("hold", gate, 1);
    gate_on_i = 0;
    wgate(0, m);
    chk("cmdoff", m <= 4, 1);
    wlvl(1, n);
    $display("test ext done");
    gate_on_i = 1;
    wgate(1, n);
    step(10);
    sec_uv_i = 1;
    wgate(0, m);
    chk("uvdly", m inside {[48:54]}, 1);
    step(100);
    chk("uvlow", gdfs_if_i.stat_lvl, 0);
    chk("uvcause", cause, GDFS_F_UV);
    sec_uv_i = 0;
    wlvl(1, n);
    $display("test uv done");
    gate_on_i = 0;
    step(10);
    gate_on_i = 1;
    wgate(1, n);
    step(10);
    prim_uv_i = 1;
    step(1);
    chk("primon", gate, 1);
    chk("blk", blocked, 1);
    wgate(0, m);
    chk("primoff", gate, 0);
    step(5);
    chk("primcmd", gdfs_if_i.cmd_n, 1);
    prim_uv_i = 0;
    $display("test prim done");
    tally_and_finish;
  end
  // Watchdog well beyond the expected run
  initial begin
    #300000;
    n_fail++;
    tally_and_finish;
  end
endmodule
